// *** tdm_stream_timing_and_delay.sv ***
// Purpose: Per-stream input delay, output advance and switch delay
// Assumes: link_clk bit clock of 8 ref_clk cycles, 256 bits a frame
// Notes:   Three frame banks of switched data; async-read arrays
`include "tdm_timing_params.svh"
module tdm_stream_timing_and_delay (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic [10:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        link_clk,
   input  wire logic        frame_pulse_n,
   input  wire logic [31:0] serial_input_stream,
   output logic      [31:0] serial_output_stream,
   output logic      [15:0] external_hiz_strobe
);
   logic [33:0]                 sync1;
   logic [33:0]                 sync2;
   logic                        lclk_d;
   logic                        fall;
   logic                        fb;
   logic [7:0]                  bitcnt;
   logic [2:0]                  phase;
   logic                        pstep;
   tdm_timing_pkg::bank_t       bank;
   logic [9:0]                  gq;
   tdm_timing_pkg::chan_t       gch;
   logic [5:0]                  seq;
   logic [4:0]                  k;
   tdm_timing_pkg::reg_word_t   cr;
   tdm_timing_pkg::reg_word_t   sicr [32];
   tdm_timing_pkg::reg_word_t   socr [32];
   tdm_timing_pkg::reg_word_t   act_sicr [32];
   tdm_timing_pkg::reg_word_t   act_socr [32];
   tdm_timing_pkg::reg_word_t   cm_mem [1024];
   logic [7:0]                  data_mem [3072];
   logic [8:0]                  hold [128];
   logic [7:0]                  cap_byte [32];
   tdm_timing_pkg::chan_t       cap_ch [32];
   logic [31:0]                 pend;

   // Bank arithmetic modulo three
   function automatic tdm_timing_pkg::bank_t inc3(input tdm_timing_pkg::bank_t b);
      inc3 = (b == 2'h2) ? 2'h0 : b + 2'h1;
   endfunction

   function automatic tdm_timing_pkg::bank_t sub3(input tdm_timing_pkg::bank_t a,
                                                  input logic [1:0] o);
      logic [2:0] t;
      t = {1'b0, a} + 3'h3 - {1'b0, o};
      if (t >= 3'h3) begin
         t = t - 3'h3;
      end
      sub3 = t[1:0];
   endfunction

   // Two-flop synchronisers on every pin from the link
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sync1 <= {34{1'b1}};
         sync2 <= {34{1'b1}};
         lclk_d <= 1'b1;
      end else begin
         sync1 <= {link_clk, frame_pulse_n, serial_input_stream};
         sync2 <= sync1;
         lclk_d <= sync2[33];
      end
   end

   assign fall = lclk_d & ~sync2[33];
   assign fb   = fall & ~sync2[32];   // Frame boundary: falling edge with pulse low

   // Bit counter and eighth-bit phase; phase holds at 7 if the link stalls
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         bitcnt <= 8'h00;
         phase  <= 3'h0;
         pstep  <= 1'b0;
         bank   <= 2'h0;
      end else if (fall) begin
         phase <= 3'h0;
         pstep <= 1'b1;
         if (fb) begin
            bitcnt <= 8'h00;
            bank   <= inc3(bank);
         end else begin
            bitcnt <= bitcnt + 8'h01;
         end
      end else begin
         pstep <= (phase != 3'h7);
         if (phase != 3'h7) begin
            phase <= phase + 3'h1;
         end
      end
   end

   assign gq  = {bitcnt, phase[2:1]};
   assign gch = bitcnt[7:3];
   assign seq = {bitcnt[2:0], phase};
   assign k   = seq[4:0];

   // Software registers
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cr <= `CR_RST;
         for (int i = 0; i < 32; i++) begin
            sicr[i] <= `SICR_RST;
            socr[i] <= `SOCR_RST;
         end
      end else if (reg_wr) begin
         if (reg_addr == `CR_ADDR) begin
            cr <= reg_wdata;
         end
         if (reg_addr[10:5] == `SICR_SEL) begin
            sicr[reg_addr[4:0]] <= reg_wdata;
         end
         if (reg_addr[10:5] == `SOCR_SEL) begin
            socr[reg_addr[4:0]] <= reg_wdata;
         end
      end
   end

   // Connection words take effect at once, per channel
   always_ff @(posedge ref_clk) begin
      if (reg_wr && reg_addr[10]) begin
         cm_mem[reg_addr[9:0]] <= reg_wdata;
      end
   end

   // Working copies change only at a frame edge, never mid-frame
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         for (int i = 0; i < 32; i++) begin
            act_sicr[i] <= `SICR_RST;
            act_socr[i] <= `SOCR_RST;
         end
      end else if (fb) begin
         for (int i = 0; i < 32; i++) begin
            act_sicr[i] <= sicr[i];
            act_socr[i] <= socr[i];
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
      end else if (!reg_rd) begin
         reg_rdata <= 16'h0000;
      end else if (reg_addr == `CR_ADDR) begin
         reg_rdata <= cr;
      end else if (reg_addr == `STAT_ADDR) begin
         reg_rdata <= {6'h00, bank, bitcnt};
      end else if (reg_addr[10:5] == `SICR_SEL) begin
         reg_rdata <= sicr[reg_addr[4:0]];
      end else if (reg_addr[10:5] == `SOCR_SEL) begin
         reg_rdata <= socr[reg_addr[4:0]];
      end else if (reg_addr[10]) begin
         reg_rdata <= cm_mem[reg_addr[9:0]];
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // Per-stream input capture with whole-bit delay and sample point
   for (genvar i = 0; i < 32; i++) begin : g_in
      logic [7:0] lbit;
      logic [2:0] smp_ph;
      logic [1:0] smp;
      logic [7:0] shreg;
      logic [7:0] next_shreg;

      assign smp  = act_sicr[i][`SICR_SMP_LSB +: 2];
      // Logical bit lags the frame by the programmed delay
      assign lbit = bitcnt - {5'h00, act_sicr[i][`SICR_BD_LSB +: 3]};
      // Code c samples at quarter c+1; 16M only at 1/2 or 4/4
      assign smp_ph = act_sicr[i][`RATE16_BIT] ?
                      ((smp == 2'h3) ? 3'h7 : 3'h3) :
                      {smp, 1'b1};
      assign next_shreg = {shreg[6:0], sync2[i]};

      always_ff @(posedge ref_clk) begin
         if (!resetn) begin
            shreg       <= 8'h00;
            cap_byte[i] <= 8'h00;
            cap_ch[i]   <= 5'h00;
            pend[i]     <= 1'b0;
         end else begin
            if (pstep && phase == smp_ph) begin
               shreg <= next_shreg;
            end
            // Completed byte beats the writer's clear
            if (pstep && phase == smp_ph && lbit[2:0] == 3'h7) begin
               cap_byte[i] <= next_shreg;
               cap_ch[i]   <= lbit[7:3];
               pend[i]     <= 1'b1;
            end else if (k == i) begin
               pend[i] <= 1'b0;
            end
         end
      end
   end

   // Writer: visits each stream twice a channel time
   always_ff @(posedge ref_clk) begin
      if (pend[k]) begin
         // A byte finished after the frame edge belongs to the old frame
         data_mem[{(cap_ch[k] > gch) ? sub3(bank, 2'h1) : bank, k, cap_ch[k]}]
            <= cap_byte[k];
      end
   end

   // Reader: in the first half of channel c, prepares channel c+2
   tdm_timing_pkg::chan_t     tc;
   tdm_timing_pkg::reg_word_t cmw;
   tdm_timing_pkg::chan_t     src_ch;
   tdm_timing_pkg::chan_t     src_st;
   logic [5:0]                diff;
   logic [1:0]                off;
   tdm_timing_pkg::bank_t     tgt;
   logic [8:0]                next_hold;

   assign tc     = gch + 5'h02;
   assign cmw    = cm_mem[{k, tc}];
   assign src_ch = cmw[`CM_SCH_LSB +: 5];
   assign src_st = cmw[`CM_SST_LSB +: 5];
   assign diff   = {1'b0, tc} - {1'b0, src_ch};
   assign tgt    = (tc < gch) ? inc3(bank) : bank;

   // Frames back to read from
   always_comb begin
      off = 2'h2;
      if (cmw[`CM_VAR_BIT]) begin
         if (diff[5] || diff == 6'h00) begin
            off = 2'h1;
         end else if (diff < 6'h07) begin
            off = 2'h1;
         end else if (diff == 6'h07) begin
            off = (k >= src_st) ? 2'h0 : 2'h1;
         end else begin
            off = 2'h0;
         end
      end
   end

   // Byte and drive flag for the prepared slot
   always_comb begin
      next_hold = {1'b0, `IDLE_BYTE};
      if (!cmw[`CM_MODE_BIT]) begin
         if (cmw[`CM_VAR_BIT] && !cr[`CR_CHIPWIDE_VARIABLE_DELAY_ENABLE_BIT]) begin
            next_hold = {1'b1, `IDLE_BYTE};
         end else begin
            next_hold = {1'b1, data_mem[{sub3(tgt, off), src_st, src_ch}]};
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         for (int j = 0; j < 128; j++) begin
            hold[j] <= {1'b0, `IDLE_BYTE};
         end
      end else if (!seq[5]) begin
         hold[{k, tc[1:0]}] <= next_hold;
      end
   end

   // Per-stream output advance; strobe timing on streams 0 to 15
   for (genvar i = 0; i < 32; i++) begin : g_out
      logic [1:0] fa;
      logic [2:0] hzc;
      logic [2:0] hzq;
      logic [4:0] adv;
      logic [9:0] p;
      logic [9:0] p2;
      logic [8:0] pw;

      // 16M drops quarter steps by clearing the low quarter bit
      assign fa  = act_socr[i][`SOCR_FA_LSB +: 2] &
                   (act_socr[i][`RATE16_BIT] ? 2'h2 : 2'h3);
      assign hzc = (act_socr[i][`SOCR_HZ_LSB +: 3] > 3'h4) ?
                   3'h4 : act_socr[i][`SOCR_HZ_LSB +: 3];
      assign hzq = hzc & (act_socr[i][`RATE16_BIT] ? 3'h6 : 3'h7);
      assign adv = {act_socr[i][`SOCR_AD_LSB +: 3], fa};
      assign p   = gq + {5'h00, adv};
      assign p2  = p + {7'h00, hzq};
      assign pw  = hold[{5'(i), p[6:5]}];

      always_ff @(posedge ref_clk) begin
         if (!resetn) begin
            serial_output_stream[i] <= 1'b1;
         end else begin
            serial_output_stream[i] <= pw[~p[4:2]];
         end
      end

      if (i < 16) begin : g_hz
         // High means the external driver should float the line
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               external_hiz_strobe[i] <= 1'b1;
            end else begin
               external_hiz_strobe[i] <= ~hold[{5'(i), p2[6:5]}][8];
            end
         end
      end
   end
endmodule // tdm_stream_timing_and_delay

// *** tdm_timing_params.svh ***
// Purpose: Constants for per-stream TDM timing and throughput delay
// Assumes: 100 MHz ref_clk, one link clock period per serial bit
// Notes:   Offsets are word addresses on the plain register port
`ifndef TDM_TIMING_PARAMS_SVH
`define TDM_TIMING_PARAMS_SVH
`define CR_ADDR        11'h000
`define STAT_ADDR      11'h001
`define SICR_SEL       6'h08
`define SOCR_SEL       6'h09
`define CR_CHIPWIDE_VARIABLE_DELAY_ENABLE_BIT   4
`define CR_RST         16'h0000
`define SICR_RST       16'h0020
`define SOCR_RST       16'h0000
`define RATE16_BIT     0
`define SICR_SMP_LSB   4
`define SICR_BD_LSB    6
`define SOCR_AD_LSB    4
`define SOCR_FA_LSB    7
`define SOCR_HZ_LSB    9
`define CM_MODE_BIT    0
`define CM_SCH_LSB     1
`define CM_SST_LSB     9
`define CM_VAR_BIT     14
`define IDLE_BYTE      8'hFF
`endif

// *** tdm_timing_pkg.sv ***
// Purpose: Types shared by the TDM timing block
// Assumes: 32 streams, 32 channels per frame
// Notes:   Constants live in tdm_timing_params.svh
package tdm_timing_pkg;
   typedef logic [15:0] reg_word_t;
   typedef logic [1:0]  bank_t;
   typedef logic [4:0]  chan_t;
endpackage

// *** tdm_timing_checker.sv ***
// Purpose: Port properties of the TDM stream timing block
// Assumes: One ref_clk domain, synchronous active-low reset
// Notes:   Bound from the testbench top file
`include "tdm_timing_params.svh"
module tdm_timing_checker (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic [10:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [31:0] serial_output_stream,
   input wire logic [15:0] external_hiz_strobe
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   // Write followed at once by a read of the same word
   sequence wr_rd(hit);
      reg_wr && hit ##1 reg_rd && reg_addr == $past(reg_addr);
   endsequence
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside its slot");
   chk_reset_idle: assert property (
      !$past(resetn) |-> &serial_output_stream && &external_hiz_strobe)
      else $error("outputs not idle after reset");
   chk_ctrl_readback: assert property (
      wr_rd(reg_addr == 11'h000) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("control word readback wrong");
   chk_in_readback: assert property (
      wr_rd(reg_addr[10:5] == `SICR_SEL) |=>
      (reg_rdata & 16'h01F1) == ($past(reg_wdata, 2) & 16'h01F1))
      else $error("input control readback wrong");
   chk_out_readback: assert property (
      wr_rd(reg_addr[10:5] == `SOCR_SEL) |=>
      (reg_rdata & 16'h0FF1) == ($past(reg_wdata, 2) & 16'h0FF1))
      else $error("output control readback wrong");
   chk_unmapped_rd: assert property (reg_rd && reg_addr == 11'h200 |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_data_quarter: assert property (
      $changed(serial_output_stream[0]) |=> $stable(serial_output_stream[0]))
      else $error("output bit shorter than a quarter window");
   chk_hiz_quarter: assert property (
      $changed(external_hiz_strobe[0]) |=> $stable(external_hiz_strobe[0]))
      else $error("strobe shorter than a quarter window");
endmodule // tdm_timing_checker

// *** tdm_peer.sv ***
// Purpose: Peer TDM device on the serial backplane side
// Assumes: Free-running 80 ns bit clock, 256 bits a frame
// Notes:   Stream 1 may be sent late by skew bits
module tdm_peer (
   output logic            link_clk,
   output logic            frame_pulse_n,
   output logic [31:0]     serial_input_stream,
   output logic [7:0]      bit_idx,
   output logic [7:0]      frame_no,
   input  wire logic [2:0] skew
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] p;
   logic [15:0] q;
   logic [7:0]  b;
   function automatic logic [7:0] pat(logic [7:0] f, int s, logic [4:0] c);
      return {f[1:0], s[0], c};
   endfunction
   // Offset start so link edges never meet ref_clk edges
   initial begin
      link_clk = 1'b1;
      frame_pulse_n = 1'b1;
      bit_idx = 8'hFF;
      frame_no = 8'h00;
      serial_input_stream = '1;
      #13;
      forever #40 link_clk = ~link_clk;
   end
   // Pulse straddles the falling edge that opens bit 0
   always @(posedge link_clk) frame_pulse_n <= (bit_idx != 8'hFF);
   // Launch each bit on the falling edge, channel bytes MSB first
   always @(negedge link_clk) begin
      p = {frame_no, bit_idx} + 16'h0001;
      bit_idx <= p[7:0];
      frame_no <= p[15:8];
      for (int s = 0; s < 32; s++) begin
         q = p - ((s == 1) ? 16'(skew) : 16'h0000);
         b = pat(q[15:8], s, q[7:3]);
         serial_input_stream[s] <= b[~q[2:0]];
      end
   end
endmodule // tdm_peer

// *** testbench.sv ***
// Purpose: Self-checking bench for the TDM stream timing block
// Assumes: Peer model supplies link clock, frame pulse and data
// Notes:   Rebuilds stream 0 bytes and checks them against the peer
`include "tdm_timing_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [10:0] reg_addr = 11'h000;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata, d, external_hiz_strobe;
   logic [31:0] serial_input_stream, serial_output_stream;
   logic        link_clk, frame_pulse_n;
   logic [7:0]  bit_idx, frame_no, sh;
   logic [7:0]  got [32];
   logic [7:0]  got_f [32];
   logic        hz [32];
   logic [2:0]  adv = 3'h0;
   logic [2:0]  skew = 3'h0;
   int          num_errors = 0;
   int          checks = 0;
   // Output channel, source channel, source stream, frame lag
   int cn [8] = '{10, 5, 4, 20, 21, 12, 30, 0};
   int cm [8] = '{2, 3, 4, 13, 14, 20, 1, 31};
   int cs [8] = '{0, 0, 0, 1, 0, 1, 0, 1};
   int cl [8] = '{0, 1, 1, 1, 0, 2, 2, 2};
   always #5 ref_clk = ~ref_clk;
   tdm_stream_timing_and_delay i_tdm_stream_timing_and_delay (.ref_clk, .resetn, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_clk, .frame_pulse_n,
      .serial_input_stream, .serial_output_stream, .external_hiz_strobe);
   tdm_peer i_tdm_peer (.link_clk, .frame_pulse_n, .serial_input_stream, .bit_idx,
      .frame_no, .skew);
   function automatic logic [7:0] pat(logic [7:0] f, int s, int c);
      return {f[1:0], s[0], c[4:0]};
   endfunction
   // Peer index is read before its update, so it names the bit just ended
   always @(negedge link_clk) begin : sampler
      logic [15:0] p;
      p = {frame_no, bit_idx} + {13'h0000, adv};
      sh = {sh[6:0], serial_output_stream[0]};
      if (p[2:0] == 3'h7) begin
         got[p[7:3]] = sh;
         got_f[p[7:3]] = p[15:8];
         hz[p[7:3]] = external_hiz_strobe[0];
      end
   end
   task automatic check(input logic [15:0] act, input logic [15:0] exp);
      checks++;
      if (act !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, act, exp);
      end
   endtask
   task automatic wr(input logic [10:0] a, input logic [15:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [10:0] a);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
      @(posedge ref_clk);
   endtask
   // Bounded wait for k peer frame boundaries
   task automatic frames(input int k);
      logic [7:0] f0;
      f0 = frame_no;
      for (int i = 0; i < 2100 * k && frame_no != 8'(f0 + k); i++) @(posedge ref_clk);
      if (frame_no != 8'(f0 + k)) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic verify();
      for (int i = 0; i < 8; i++)
         check(got[cn[i]], pat(got_f[cn[i]] - 8'(cl[i]), cs[i], cm[i]));
      check(got[25], 16'h00FF);
      check(hz[25], 1'b1);
      check(hz[10], 1'b0);
   endtask
   task automatic summarize();
      $display("num_errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      // Every stream 0 word gets a value; unused channels stay idle
      // Idle edge between writes keeps the strobe single-driven per step
      for (int c = 0; c < 32; c++) begin
         wr(11'h400 + 11'(c), 16'h0001);
         @(posedge ref_clk);
      end
      for (int i = 0; i < 8; i++) begin
         wr(11'h400 + 11'(cn[i]), {1'b0, cl[i] < 2, 5'(cs[i]), 3'h0, 5'(cm[i]), 1'b0});
         @(posedge ref_clk);
      end
      rd(11'h000);
      check(d, 16'h0000);
      rd({`SICR_SEL, 5'h00});
      check(d, `SICR_RST);
      rd({`SOCR_SEL, 5'h1F});
      check(d, `SOCR_RST);
      wr(11'h000, 16'h0010);
      rd(11'h000);
      check(d, 16'h0010);
      wr(11'h200, 16'h1234);
      rd(11'h200);
      check(d, 16'h0000);
      frames(4);
      verify();
      // Late stream 1 and advanced stream 0, lowest sample point
      wr({`SICR_SEL, 5'h01}, 16'h0005 << `SICR_BD_LSB);
      rd({`SICR_SEL, 5'h01});
      check(d, 16'h0005 << `SICR_BD_LSB);
      wr({`SOCR_SEL, 5'h00}, 16'h0003 << `SOCR_AD_LSB);
      rd({`SOCR_SEL, 5'h00});
      check(d, 16'h0003 << `SOCR_AD_LSB);
      skew <= 3'h5;
      adv <= 3'h3;
      frames(4);
      verify();
      summarize();
   end
endmodule // testbench
bind tdm_stream_timing_and_delay tdm_timing_checker i_tdm_timing_checker (.ref_clk, .resetn,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_output_stream,
   .external_hiz_strobe);
